// ==== ciex_pkg.sv ====
// constants and types for the instruction execute subset
package ciex_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses on the axi4-lite bus
    // ------------------------------------------------------------
    localparam logic [7:0] CIEX_CMD_OFF    = 8'h00; // write launches an operation
    localparam logic [7:0] CIEX_WREG_OFF   = 8'h04; // working register
    localparam logic [7:0] CIEX_STAT_OFF   = 8'h08; // flags and busy
    localparam logic [7:0] CIEX_PC_OFF     = 8'h0c; // program counter
    localparam logic [7:0] CIEX_SP_OFF     = 8'h10; // stack depth
    localparam logic [7:0] CIEX_WDOG_OFF   = 8'h14; // watchdog counter
    localparam logic [7:0] CIEX_MEMWIN_OFF = 8'h80; // data memory window base
    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int CIEX_OPC_LSB  = 24; // opcode in bits 27:24
    localparam int CIEX_ADDR_LSB = 8;  // memory address bits 15:8, call target bits 19:8
    localparam int CIEX_BIT_LSB  = 20; // bit select in bits 22:20
    // status bits
    localparam int CIEX_ST_Z    = 0;
    localparam int CIEX_ST_C    = 1;
    localparam int CIEX_ST_HC   = 2; // half carry
    localparam int CIEX_ST_SW   = 3; // signed wrap
    localparam int CIEX_ST_EXP  = 4; // watchdog expired
    localparam int CIEX_ST_PWD  = 5; // power down
    localparam int CIEX_ST_BUSY = 8;
    // reset values
    localparam logic [7:0]  CIEX_WREG_RST = 8'h00;
    localparam logic [15:0] CIEX_WDOG_RST = 16'h0000;
    localparam int CIEX_CALL_CYCLES = 2; // call occupies two instruction cycles
    // ------------------------------------------------------------
    // operations
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CIEX_OP_NOP          = 4'h0,
        CIEX_OP_ADD_MEM      = 4'h1,
        CIEX_OP_ADD_IMM      = 4'h2,
        CIEX_OP_ADC_MEM      = 4'h3,
        CIEX_OP_ADC_TO_MEM   = 4'h4, // sum_with_carry_to_memory
        CIEX_OP_ADD_TO_MEM   = 4'h5, // sum_into_memory
        CIEX_OP_AND_MEM      = 4'h6,
        CIEX_OP_AND_IMM      = 4'h7,
        CIEX_OP_AND_TO_MEM   = 4'h8, // conjunction_into_memory
        CIEX_OP_CALL         = 4'h9,
        CIEX_OP_ZERO_BYTE    = 4'ha, // zero_memory_byte
        CIEX_OP_ZERO_BIT     = 4'hb,
        CIEX_OP_KICK         = 4'hc, // watchdog_kick
        CIEX_OP_PREKICK1     = 4'hd, // watchdog_prekick_first
        CIEX_OP_PREKICK2     = 4'he, // watchdog_prekick_second
        CIEX_OP_INVERT       = 4'hf  // invert_memory_byte
    } ciex_op_t;
endpackage

// ==== ciex_core.sv ====
// instruction execute subset with axi4-lite register access
`timescale 1ns/100ps
module ciex_core
    import ciex_pkg::*;
#(
    parameter int MEM_WORDS   = 256, // data memory bytes
    parameter int PC_W        = 12,  // program counter width
    parameter int STACK_DEPTH = 8    // subroutine nesting levels
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        wdog_tick,      // watchdog count pulse
    output logic             watchdog_expired_flag,
    output logic             powerdown_flag
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam int MA_W = $clog2(MEM_WORDS);
    logic [7:0]      mem_r [MEM_WORDS];     // data memory
    logic [PC_W-1:0] stack_r [STACK_DEPTH]; // return stack
    logic [7:0]      working_register_r;
    logic            null_result_flag_r;
    logic            msb_spill_flag_r;
    logic            half_carry_flag_r;
    logic            signed_wrap_flag_r;
    logic [PC_W-1:0] pc_r;
    logic [SP_W-1:0] sp_r;
    logic [15:0]     wdog_r;                // watchdog_counter
    logic [1:0]      last_pre_r;            // 0 none, 1 first, 2 second
    logic            busy_r;                // second call cycle pending
    logic [PC_W-1:0] call_tgt_r;
    // ------------------------------------------------------------
    // bus handshake state
    // ------------------------------------------------------------
    logic            aw_got_r, w_got_r;
    logic [7:0]      aw_r;
    logic [31:0]     wd_r;
    logic [3:0]      ws_r;
    logic            bvalid_r, rvalid_r, arready_r;
    logic            awready_r, wready_r;   // registered so outputs leave flops
    logic [31:0]     rdata_r;
    logic [1:0]      bresp_r, rresp_r;
    logic            expired_r;             // watchdog_expired_flag
    logic            pwrdn_r;               // powerdown_flag, nothing here sets it

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign watchdog_expired_flag = expired_r;
    assign powerdown_flag        = pwrdn_r;

    // write commit once both halves are held
    wire         wr_go    = aw_got_r & w_got_r & ~bvalid_r;
    wire         wr_cmd   = wr_go & (aw_r == CIEX_CMD_OFF) & ws_r[3];
    wire         wr_wreg  = wr_go & (aw_r == CIEX_WREG_OFF) & ws_r[0];
    wire         wr_mem   = wr_go & aw_r[7] & ws_r[0];
    wire         wr_ok    = (aw_r == CIEX_CMD_OFF) | (aw_r == CIEX_WREG_OFF) | aw_r[7];
    // command decode; commands during busy are dropped
    wire         cmd_go   = wr_cmd & ~busy_r;
    wire [3:0]   opc      = wd_r[CIEX_OPC_LSB +: 4];
    wire [MA_W-1:0] maddr = wd_r[CIEX_ADDR_LSB +: MA_W];
    wire [2:0]   bsel     = wd_r[CIEX_BIT_LSB +: 3];
    wire [7:0]   imm      = wd_r[7:0];
    wire [7:0]   mval     = mem_r[maddr];
    // ------------------------------------------------------------
    // arithmetic datapath
    // ------------------------------------------------------------
    wire         use_c    = (opc == CIEX_OP_ADC_MEM) | (opc == CIEX_OP_ADC_TO_MEM);
    wire [7:0]   opb      = (opc == CIEX_OP_ADD_IMM) | (opc == CIEX_OP_AND_IMM) ? imm : mval;
    wire         cin      = use_c & msb_spill_flag_r;
    wire [4:0]   lo_sum   = {1'b0, working_register_r[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    wire [8:0]   sum      = {1'b0, working_register_r} + {1'b0, opb} + {8'h00, cin};
    wire         ovf      = (working_register_r[7] == opb[7]) & (sum[7] != opb[7]);
    wire [7:0]   andv     = working_register_r & opb;
    wire [7:0]   inv      = ~mval;
    wire         is_add   = (opc == CIEX_OP_ADD_MEM) | (opc == CIEX_OP_ADD_IMM)
                          | (opc == CIEX_OP_ADC_MEM) | (opc == CIEX_OP_ADC_TO_MEM)
                          | (opc == CIEX_OP_ADD_TO_MEM);
    wire         is_and   = (opc == CIEX_OP_AND_MEM) | (opc == CIEX_OP_AND_IMM)
                          | (opc == CIEX_OP_AND_TO_MEM);
    wire [7:0]   bit_clr  = mval & ~(8'h01 << bsel);
    // memory destination and value
    wire         mem_dst  = (opc == CIEX_OP_ADC_TO_MEM) | (opc == CIEX_OP_ADD_TO_MEM)
                          | (opc == CIEX_OP_AND_TO_MEM) | (opc == CIEX_OP_ZERO_BYTE)
                          | (opc == CIEX_OP_ZERO_BIT) | (opc == CIEX_OP_INVERT);
    wire [7:0]   mem_val  = (opc == CIEX_OP_AND_TO_MEM) ? andv :
                            (opc == CIEX_OP_ZERO_BYTE) ? 8'h00 :
                            (opc == CIEX_OP_ZERO_BIT) ? bit_clr :
                            (opc == CIEX_OP_INVERT) ? inv :
                            sum[7:0];
    wire         wreg_dst = (opc == CIEX_OP_ADD_MEM) | (opc == CIEX_OP_ADD_IMM)
                          | (opc == CIEX_OP_ADC_MEM) | (opc == CIEX_OP_AND_MEM)
                          | (opc == CIEX_OP_AND_IMM);
    wire [7:0]   wreg_val = is_and ? andv : sum[7:0];
    wire [7:0]   zsrc     = is_and ? andv : (opc == CIEX_OP_INVERT) ? inv : sum[7:0];
    // watchdog pre-clear pairing: act only on the alternate one
    wire         pre1     = cmd_go & (opc == CIEX_OP_PREKICK1);
    wire         pre2     = cmd_go & (opc == CIEX_OP_PREKICK2);
    wire         pre_fire = (pre1 & (last_pre_r == 2'd2)) | (pre2 & (last_pre_r == 2'd1));
    wire         kick     = (cmd_go & (opc == CIEX_OP_KICK)) | pre_fire;

    // ------------------------------------------------------------
    // bus write channel
    // ------------------------------------------------------------
    wire         aw_take    = s_axi_awvalid & awready_r;
    wire         w_take     = s_axi_wvalid & wready_r;
    wire         aw_got_nxt = ~wr_go & (aw_got_r | aw_take);
    wire         w_got_nxt  = ~wr_go & (w_got_r | w_take);
    wire         bvalid_nxt = wr_go | (bvalid_r & ~s_axi_bready);
    // ready is built from next state, so it rises in the same cycle a
    // combinational ready would, yet comes straight from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_r      <= 8'h00;
            wd_r      <= 32'h0000_0000;
            ws_r      <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'b00;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                wd_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                bresp_r <= wr_ok ? 2'b00 : 2'b10; // slverr on unmapped
            end
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            bvalid_r  <= bvalid_nxt;
            awready_r <= ~aw_got_nxt & ~bvalid_nxt;
            wready_r  <= ~w_got_nxt & ~bvalid_nxt;
        end
    end

    // ------------------------------------------------------------
    // bus read channel, one cycle to data
    // ------------------------------------------------------------
    wire [7:0]  ra    = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] stat  = {23'h0, busy_r, 2'b00, pwrdn_r, expired_r, signed_wrap_flag_r,
                         half_carry_flag_r, msb_spill_flag_r, null_result_flag_r};
    wire        r_hit = (ra == CIEX_CMD_OFF) | (ra == CIEX_WREG_OFF) | (ra == CIEX_STAT_OFF)
                      | (ra == CIEX_PC_OFF) | (ra == CIEX_SP_OFF) | (ra == CIEX_WDOG_OFF) | ra[7];
    // last pushed return address shown above the depth until an overflow, then slot 7; garbage while empty
    wire [PC_W-1:0] tos = stack_r[(SP_W-1)'(sp_r - SP_W'(1))];
    wire [31:0] rmux  = (ra == CIEX_WREG_OFF) ? {24'h0, working_register_r} :
                        (ra == CIEX_STAT_OFF) ? stat :
                        (ra == CIEX_PC_OFF)   ? {{(32-PC_W){1'b0}}, pc_r} :
                        (ra == CIEX_SP_OFF)   ? {{(16-PC_W){1'b0}}, tos, {(16-SP_W){1'b0}}, sp_r} :
                        (ra == CIEX_WDOG_OFF) ? {16'h0, wdog_r} :
                        ra[7] ? {24'h0, mem_r[MA_W'(ra[6:2])]} : 32'h0000_0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= 2'b00;
        end else begin
            arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
            if (s_axi_arvalid & arready_r) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rmux;
                rresp_r  <= r_hit ? 2'b00 : 2'b10;
            end else if (rvalid_r & s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // data memory; window covers the first 32 bytes
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (cmd_go & mem_dst) begin
            mem_r[maddr] <= mem_val;
        end else if (wr_mem) begin
            mem_r[MA_W'(aw_r[6:2])] <= wd_r[7:0];
        end
    end

    // ------------------------------------------------------------
    // working register and arithmetic flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            working_register_r <= CIEX_WREG_RST;
            null_result_flag_r <= 1'b0;
            msb_spill_flag_r   <= 1'b0;
            half_carry_flag_r  <= 1'b0;
            signed_wrap_flag_r <= 1'b0;
        end else if (cmd_go) begin
            if (wreg_dst) begin
                working_register_r <= wreg_val;
            end
            if (is_add | is_and | (opc == CIEX_OP_INVERT)) begin
                null_result_flag_r <= (zsrc == 8'h00);
            end
            if (is_add) begin
                msb_spill_flag_r   <= sum[8];
                half_carry_flag_r  <= lo_sum[4];
                signed_wrap_flag_r <= ovf;
            end
        end else if (wr_wreg) begin
            working_register_r <= wd_r[7:0];
        end
    end

    // ------------------------------------------------------------
    // program counter and stack; call spans two cycles
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_r       <= '0;
            sp_r       <= '0;
            busy_r     <= 1'b0;
            call_tgt_r <= '0;
        end else if (busy_r) begin
            pc_r   <= call_tgt_r;
            busy_r <= 1'b0;
        end else if (cmd_go & (opc == CIEX_OP_CALL)) begin
            // overflow overwrites the bottom slot while the depth holds at STACK_DEPTH
            stack_r[sp_r[SP_W-2:0]] <= pc_r + PC_W'(1);
            if (sp_r != SP_W'(STACK_DEPTH)) sp_r <= sp_r + SP_W'(1);
            call_tgt_r <= wd_r[CIEX_ADDR_LSB +: PC_W];
            busy_r     <= 1'b1;
        end else if (cmd_go) begin
            pc_r <= pc_r + PC_W'(1);
        end
    end

    // ------------------------------------------------------------
    // watchdog counter and its flags
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdog_r     <= CIEX_WDOG_RST;
            expired_r  <= 1'b0;
            pwrdn_r    <= 1'b0;
            last_pre_r <= 2'd0;
        end else begin
            if (kick) begin
                wdog_r  <= CIEX_WDOG_RST;
                pwrdn_r <= 1'b0;
            end else if (wdog_tick) begin
                wdog_r <= wdog_r + 16'h0001;
            end
            // a wrap in the same cycle as a clear still sets the flag
            if (wdog_tick & (wdog_r == 16'hffff)) begin
                expired_r <= 1'b1;
            end else if (kick) begin
                expired_r <= 1'b0;
            end
            if (pre_fire | (cmd_go & (opc == CIEX_OP_KICK))) last_pre_r <= 2'd0;
            else if (pre1) last_pre_r <= 2'd1;
            else if (pre2) last_pre_r <= 2'd2;
        end
    end
endmodule // ciex_core

// ==== ciex_core_assertions.sv ====
// port-level checker for the instruction execute core
`timescale 1ns/100ps
module ciex_checker
    import ciex_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        wdog_tick,
    input wire logic        watchdog_expired_flag,
    input wire logic        powerdown_flag
);
    // ------------------------------------------------------------
    // single clock domain, reset silences every check
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // answers must stand until taken, else software loses them
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    // bounded answer latency
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    bresp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("write response code illegal");
    // flags only clear through an executed command
    flag_clear_cause_a: assert property (
        $fell(watchdog_expired_flag) && $past(aresetn) |-> s_axi_bvalid)
        else $error("expired flag cleared without command");
    // only a counter wrap can set the expired flag
    flag_set_cause_a: assert property ($rose(watchdog_expired_flag)
        |-> $past(wdog_tick) || $past(wdog_tick, 2)) else $error("expired flag set without tick");
    // nothing in this subset enters power down
    pwrdn_quiet_a: assert property (!powerdown_flag) else $error("powerdown flag set");

    // ------------------------------------------------------------
    // main scenario coverage
    // ------------------------------------------------------------
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    cover property ($fell(watchdog_expired_flag));
endmodule // ciex_checker

bind ciex_core ciex_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdog_tick(wdog_tick),
    .watchdog_expired_flag(watchdog_expired_flag), .powerdown_flag(powerdown_flag)
);

// ==== test_cpu_instruction_execute_subset.sv ====
// self-checking bench for the instruction execute core
`timescale 1ns/100ps
module test_cpu_instruction_execute_subset
    import ciex_pkg::*;
;
    typedef struct packed {
        logic [3:0] op;  // opcode
        logic [7:0] w;   // working register before
        logic [7:0] m;   // memory byte before
        logic [7:0] x;   // immediate
        logic [2:0] b;   // bit select
        logic [7:0] ew;  // expected working register
        logic [7:0] em;  // expected memory byte
        logic [3:0] ef;  // expected wrap, half carry, carry, zero
    } ciex_row_t;
    localparam logic [7:0] MEM3 = CIEX_MEMWIN_OFF + 8'h0c; // data byte 3
    logic        aclk = 1'b0;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, wdog_tick, watchdog_expired_flag, powerdown_flag;
    logic [31:0] rdv; // sink for reads whose data is not compared
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          failures = 0;
    int          checks = 0;
    // flags chain from row to row, so order matters
    ciex_row_t rows [14] = '{
        '{4'h1, 8'h88, 8'h88, 8'h00, 3'h0, 8'h10, 8'h88, 4'he},
        '{4'h3, 8'h7f, 8'h00, 8'h00, 3'h0, 8'h80, 8'h00, 4'hc}, // carry in
        '{4'h4, 8'h01, 8'hff, 8'h00, 3'h0, 8'h01, 8'h00, 4'h7},
        '{4'h4, 8'h10, 8'h20, 8'h00, 3'h0, 8'h10, 8'h31, 4'h0}, // carry in
        '{4'h2, 8'h50, 8'h33, 8'h50, 3'h0, 8'ha0, 8'h33, 4'h8},
        '{4'h5, 8'hff, 8'h01, 8'h00, 3'h0, 8'hff, 8'h00, 4'h7},
        '{4'h6, 8'hf0, 8'h3c, 8'h00, 3'h0, 8'h30, 8'h3c, 4'h6},
        '{4'h7, 8'h0f, 8'h55, 8'hf0, 3'h0, 8'h00, 8'h55, 4'h7},
        '{4'h8, 8'haa, 8'h0f, 8'h00, 3'h0, 8'haa, 8'h0a, 4'h6},
        '{4'ha, 8'h12, 8'h5a, 8'h00, 3'h0, 8'h12, 8'h00, 4'h6},
        '{4'hb, 8'h34, 8'hff, 8'h00, 3'h7, 8'h34, 8'h7f, 4'h6},
        '{4'hb, 8'h34, 8'h81, 8'h00, 3'h0, 8'h34, 8'h80, 4'h6},
        '{4'hf, 8'h56, 8'hff, 8'h00, 3'h0, 8'h56, 8'h00, 4'h7},
        '{4'hf, 8'h56, 8'h0f, 8'h00, 3'h0, 8'h56, 8'hf0, 4'h6}
    };

    ciex_core u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wdog_tick(wdog_tick),
        .watchdog_expired_flag(watchdog_expired_flag), .powerdown_flag(powerdown_flag)
    );

    // ------------------------------------------------------------
    // clock and bus tasks
    // ------------------------------------------------------------
    always #4 aclk = ~aclk;

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t resp %h exp %h", $time, g, e);
        end
    endtask

    // masked read and compare
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  rs;
        rd(a, d, rs);
        chk_resp(rs, 2'b00);
        chk(d & m, e);
    endtask

    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chk_resp(rs, 2'b00);
    endtask

    // launch one command word
    task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [11:0] a,
                       input logic [7:0] x);
        wok(CIEX_CMD_OFF, (32'(op) << CIEX_OPC_LSB) | (32'(b) << CIEX_BIT_LSB)
                        | (32'(a) << CIEX_ADDR_LSB) | 32'(x));
    endtask

    task automatic ticks(input int n);
        wdog_tick <= 1'b1;
        repeat (n) @(posedge aclk);
        wdog_tick <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // hang guard, well past the full wrap plus all bus traffic
    initial begin
        repeat (90000) @(posedge aclk);
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, wdog_tick, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(CIEX_WREG_OFF, 32'hff, 32'(CIEX_WREG_RST));
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'(CIEX_WDOG_RST));
        rdc(CIEX_STAT_OFF, 32'h3f, 32'h0);
        $display("test reset finished");
        foreach (rows[i]) begin
            wok(CIEX_WREG_OFF, 32'(rows[i].w));
            wok(MEM3, 32'(rows[i].m));
            run(rows[i].op, rows[i].b, 12'h003, rows[i].x);
            rdc(CIEX_WREG_OFF, 32'hff, 32'(rows[i].ew));
            rdc(MEM3, 32'hff, 32'(rows[i].em));
            rdc(CIEX_STAT_OFF, 32'h0f, 32'(rows[i].ef));
        end
        $display("test table finished");
        run(4'h9, 3'h0, 12'h123, 8'h00);
        rdc(CIEX_PC_OFF, 32'hfff, 32'h123);
        // fourteen commands ran before the call, so it pushes 0x00f
        rdc(CIEX_SP_OFF, 32'h0fff_000f, 32'h000f_0001);
        rdc(CIEX_STAT_OFF, 32'h0f, 32'h6);
        $display("test call finished");
        wr(8'h40, 32'h1, r);
        chk_resp(r, 2'b10);
        rd(8'h40, rdv, r);
        chk_resp(r, 2'b10);
        $display("test unmapped finished");
        ticks(65536);
        rdc(CIEX_STAT_OFF, 32'h30, 32'h10);
        ticks(5);
        run(4'hd, 3'h0, 12'h0, 8'h00);
        run(4'hd, 3'h0, 12'h0, 8'h00);
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'h5);
        chk(32'(watchdog_expired_flag), 32'h1);
        run(4'he, 3'h0, 12'h0, 8'h00);
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'h0);
        chk(32'({watchdog_expired_flag, powerdown_flag}), 32'h0);
        ticks(7);
        run(4'hc, 3'h0, 12'h0, 8'h00);
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'h0);
        chk(32'({watchdog_expired_flag, powerdown_flag}), 32'h0);
        ticks(3);
        run(4'he, 3'h0, 12'h0, 8'h00);
        run(4'he, 3'h0, 12'h0, 8'h00);
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'h3);
        run(4'hd, 3'h0, 12'h0, 8'h00);
        rdc(CIEX_WDOG_OFF, 32'hffff, 32'h0);
        $display("test watchdog finished");
        wok(CIEX_WREG_OFF, 32'hff);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(CIEX_WREG_OFF, 32'hff, 32'(CIEX_WREG_RST));
        rdc(CIEX_STAT_OFF, 32'h3f, 32'h0);
        $display("test second reset finished");
        end_sim();
    end
endmodule // test_cpu_instruction_execute_subset
